// ==== verification/amc_checker.sv ====
// port-level assertions for the converter mode control block
// assumes apb writes land at the access edge; shadows track written bytes
`timescale 1ns/1ps
module amc_checker
   import amc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire amc_analog_t analog_ctl,
   input wire logic conv_end_irq,
   input wire logic [1:0] conv_end_priority
);
   logic [7:0] sh_rst, sh_clk, sh_mask, sh_phi, sh_plo, sh_ana, sh_dir;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wr(logic [7:0] a);
      psel && penable && pwrite && pready && paddr == a;
   endsequence
   sequence s_rd(logic [7:0] a);
      psel && penable && !pwrite && pready && paddr == a;
   endsequence
   sequence s_unit_release;
      analog_ctl.unit_reset ##1 !analog_ctl.unit_reset;
   endsequence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sh_rst <= RST_ZERO;
         sh_clk <= RST_ZERO;
         sh_mask <= RST_IRQ_MASK;
         sh_phi <= RST_PRIO;
         sh_plo <= RST_PRIO;
         sh_ana <= RST_PORT_ANALOG;
         sh_dir <= RST_PORT_DIR;
      end
      else if (psel && penable && pwrite && pready)
      begin
         if (paddr == OFF_RESET_CTL) sh_rst <= pwdata[7:0];
         if (paddr == OFF_CLOCK_EN) sh_clk <= pwdata[7:0];
         if (paddr == OFF_IRQ_MASK) sh_mask <= pwdata[7:0];
         if (paddr == OFF_PRIO_HI) sh_phi <= pwdata[7:0];
         if (paddr == OFF_PRIO_LO) sh_plo <= pwdata[7:0];
         if (paddr == OFF_PORT_ANALOG) sh_ana <= pwdata[7:0];
         if (paddr == OFF_PORT_DIR) sh_dir <= pwdata[7:0];
      end
   end
   a_unit_reset_hold: assert property (analog_ctl.unit_reset == sh_rst[5])
      else $error("unit reset does not follow its hold bit");
   a_gate_stops_clock: assert property (!sh_clk[5] |-> !analog_ctl.conv_clock_en)
      else $error("conversion clock runs while gated");
   a_gate_blocks_write: assert property ((s_wr(OFF_MODE_FIRST) and !sh_clk[5]
      and !analog_ctl.comparator_on) |=> !analog_ctl.comparator_on)
      else $error("mode write taken while clock gated");
   a_comp_follows_bit: assert property ((s_wr(OFF_MODE_FIRST) and sh_clk[5] and !sh_rst[5])
      |=> analog_ctl.comparator_on == $past(pwdata[0]))
      else $error("comparator does not follow its bit");
   a_mask_blocks_irq: assert property (sh_mask[0] |-> !conv_end_irq)
      else $error("interrupt raised while masked");
   a_prio_split_bits: assert property (conv_end_priority == {sh_phi[0], sh_plo[0]})
      else $error("priority not built from the two bits");
   a_prio_read_back: assert property (s_rd(OFF_PRIO_HI) |-> prdata[0] == sh_phi[0])
      else $error("priority bit read back wrong");
   a_analog_pin_sel: assert property (analog_ctl.analog_select == sh_ana[3:0])
      else $error("analog select does not follow register");
   a_dir_buffer_on: assert property (analog_ctl.output_enable_n == sh_dir[3:0])
      else $error("output buffer does not follow direction");
   a_reset_clears_comp: assert property (s_unit_release |-> !analog_ctl.comparator_on)
      else $error("comparator left on in unit reset");
endmodule
bind amc_top amc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .analog_ctl(analog_ctl), .conv_end_irq(conv_end_irq),
   .conv_end_priority(conv_end_priority));

// ==== verification/amc_pins.sv ====
// analog pin and trigger source model facing the converter control block
// assumes one pclk domain; bench raises fire to ask for a hardware trigger
`timescale 1ns/1ps
module amc_pins
(
   input wire logic pclk,
   input wire logic [1:0] channel,
   input wire logic fire,
   output logic [9:0] sample_data,
   output logic hw_trigger
);
   // each pin at its own level in the low two bits, so a wrong channel shows in a 10-bit result
   assign sample_data = 10'h2A5 ^ {8'h00, channel};
   always @(posedge pclk)
      hw_trigger <= fire;
endmodule

// ==== verification/amc_top_tb.sv ====
// self-checking bench: apb register calls and conversion runs
// assumes apb read data stands at the completing access edge
`timescale 1ns/1ps
module amc_top_tb
   import amc_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, fire, pready, pslverr, hw_trigger, conv_end_irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] sample_data;
   logic [1:0] conv_end_priority;
   amc_analog_t analog_ctl;
   int bad_count, samples_checked;
   amc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hw_trigger(hw_trigger), .sample_data(sample_data),
      .analog_ctl(analog_ctl), .conv_end_irq(conv_end_irq),
      .conv_end_priority(conv_end_priority));
   amc_pins pins (.pclk(pclk), .channel(analog_ctl.channel), .fire(fire),
      .sample_data(sample_data), .hw_trigger(hw_trigger));
   always #5 pclk = ~pclk;
   task automatic stop_test();
      $display("compares %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         bad_count++;
         stop_test();
      end
      // read data is taken at the completing edge, where it stands
      rd = prdata;
      // slave error is only meaningful in the access phase
      check({31'h00000000, pslverr}, {31'h00000000, a == 8'hFC}, "slave error");
      psel <= 1'b0;
      penable <= 1'b0;
      // let the edge's register updates settle before callers look at outputs
      #1;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string what);
      xfer(1'b0, a, 32'h00000000);
      check(rd & 32'h000000FF, {24'h000000, e}, what);
   endtask
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (conv_end_irq !== 1'b1 && n < lim)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= lim)
      begin
         bad_count++;
         stop_test();
      end
   endtask
   task automatic stop_clear();
      xfer(1'b1, OFF_MODE_FIRST, 32'h00000000);
      xfer(1'b1, OFF_IRQ_REQ, 32'h00000000);
   endtask
   initial
   begin
      pclk = 0;
      presetn = 0;
      {psel, penable, pwrite, fire, paddr, pwdata} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(OFF_RESET_CTL, RST_ZERO, "reset ctl");
      rdchk(OFF_CLOCK_EN, RST_ZERO, "clock gate");
      rdchk(OFF_IRQ_MASK, RST_IRQ_MASK, "mask");
      rdchk(OFF_PORT_ANALOG, RST_PORT_ANALOG, "analog sel");
      rdchk(OFF_PORT_DIR, RST_PORT_DIR, "direction");
      check({30'h00000000, conv_end_priority}, 32'h00000003, "prio reset");
      xfer(1'b1, OFF_MODE_FIRST, 32'h00000001);
      rdchk(OFF_MODE_FIRST, 8'h00, "gated write");
      xfer(1'b1, OFF_CLOCK_EN, 32'h00000020);
      xfer(1'b1, OFF_MODE_FIRST, 32'h00000041);
      rdchk(OFF_MODE_FIRST, 8'h41, "scheme bit");
      check({31'h00000000, analog_ctl.comparator_on}, 32'h00000001, "comp on");
      xfer(1'b1, OFF_RESET_CTL, 32'h00000020);
      check({31'h00000000, analog_ctl.unit_reset}, 32'h00000001, "unit reset");
      rdchk(OFF_MODE_FIRST, 8'h00, "mode cleared");
      xfer(1'b1, OFF_RESET_CTL, 32'h00000000);
      $display("test gate and reset done");
      for (int i = 0; i < 4; i++)
      begin
         xfer(1'b1, OFF_PRIO_HI, {31'h00000000, i[1]});
         xfer(1'b1, OFF_PRIO_LO, {31'h00000000, i[0]});
         check({30'h00000000, conv_end_priority}, i, "prio level");
      end
      rdchk(OFF_PRIO_HI, 8'h01, "prio hi read");
      xfer(1'b1, OFF_PORT_ANALOG, 32'h00000005);
      xfer(1'b1, OFF_PORT_DIR, 32'h0000000A);
      check({28'h0000000, analog_ctl.analog_select}, 32'h00000005, "pins");
      check({28'h0000000, analog_ctl.output_enable_n}, 32'h0000000A, "buffers");
      xfer(1'b0, 8'hFC, 32'h00000000);
      $display("test priority and pins done");
      xfer(1'b1, OFF_IRQ_MASK, 32'h00000000);
      xfer(1'b1, OFF_MODE_FIRST, 32'h000000B9);
      rdchk(OFF_MODE_FIRST, 8'hB9, "run and divider");
      wait_irq(400);
      xfer(1'b0, OFF_RESULT, 32'h00000000);
      check(rd, 32'h0000A940, "result");
      xfer(1'b1, OFF_IRQ_MASK, 32'h00000001);
      check({31'h00000000, conv_end_irq}, 32'h00000000, "masked");
      rdchk(OFF_IRQ_REQ, 8'h01, "pending");
      stop_clear();
      rdchk(OFF_MODE_FIRST, 8'h00, "stopped");
      rdchk(OFF_IRQ_REQ, 8'h00, "cleared");
      xfer(1'b1, OFF_IRQ_MASK, 32'h00000000);
      $display("test software conversion done");
      xfer(1'b1, OFF_MODE_THIRD, 32'h00000008);
      xfer(1'b1, OFF_MODE_FIRST, 32'h000000B9);
      repeat (200) @(posedge pclk);
      check({31'h00000000, conv_end_irq}, 32'h00000000, "inside bounds");
      xfer(1'b1, OFF_LOWER_BOUND, 32'h000000B0);
      wait_irq(400);
      stop_clear();
      $display("test range check done");
      xfer(1'b1, OFF_MODE_SECOND, 32'h00000080);
      xfer(1'b1, OFF_MODE_FIRST, 32'h000000B9);
      repeat (100) @(posedge pclk);
      check({31'h00000000, conv_end_irq}, 32'h00000000, "no trigger");
      fire <= 1'b1;
      repeat (4) @(posedge pclk);
      fire <= 1'b0;
      wait_irq(400);
      stop_clear();
      $display("test hardware trigger done");
      xfer(1'b1, OFF_MODE_SECOND, 32'h000000C0);
      xfer(1'b1, OFF_MODE_FIRST, 32'h000000B9);
      @(posedge pclk);
      fire <= 1'b1;
      repeat (4) @(posedge pclk);
      fire <= 1'b0;
      wait_irq(400);
      rdchk(OFF_MODE_FIRST, 8'h39, "wait mode standby");
      stop_clear();
      $display("test hardware wait done");
      xfer(1'b1, OFF_MODE_SECOND, 32'h00000000);
      xfer(1'b1, OFF_MODE_THIRD, 32'h00000000);
      xfer(1'b1, OFF_LOWER_BOUND, 32'h00000000);
      xfer(1'b1, OFF_MODE_FIRST, 32'h000000C1);
      wait_irq(1500);
      xfer(1'b0, OFF_RESULT, 32'h00000000);
      check(rd, 32'h0000A940, "scan position 0");
      rdchk(OFF_STATUS, 8'h03, "scan walks");
      xfer(1'b1, OFF_IRQ_REQ, 32'h00000000);
      wait_irq(1500);
      xfer(1'b0, OFF_RESULT, 32'h00000000);
      check(rd, 32'h0000A900, "scan position 1");
      stop_clear();
      $display("test scan mode done");
      xfer(1'b1, OFF_MODE_THIRD, 32'h00000001);
      xfer(1'b1, OFF_MODE_FIRST, 32'h000000B9);
      wait_irq(400);
      xfer(1'b0, OFF_RESULT, 32'h00000000);
      check(rd, 32'h0000A900, "8-bit result");
      stop_clear();
      $display("test resolution done");
      stop_test();
   end
endmodule

// ==== verilog/amc_pkg.sv ====
// package for the converter mode control block: register map, fields, timing
// assumes a 32-bit apb slave, one register per aligned word
package amc_pkg;
   // register byte offsets (chosen map)
   localparam logic [7:0] OFF_RESET_CTL = 8'h00;
   localparam logic [7:0] OFF_CLOCK_EN = 8'h04;
   localparam logic [7:0] OFF_MODE_FIRST = 8'h08;
   localparam logic [7:0] OFF_MODE_SECOND = 8'h0C;
   localparam logic [7:0] OFF_MODE_THIRD = 8'h10;
   localparam logic [7:0] OFF_UPPER_BOUND = 8'h14;
   localparam logic [7:0] OFF_LOWER_BOUND = 8'h18;
   localparam logic [7:0] OFF_CHANNEL = 8'h1C;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
   localparam logic [7:0] OFF_IRQ_REQ = 8'h24;
   localparam logic [7:0] OFF_PRIO_HI = 8'h28;
   localparam logic [7:0] OFF_PRIO_LO = 8'h2C;
   localparam logic [7:0] OFF_PORT_ANALOG = 8'h30;
   localparam logic [7:0] OFF_PORT_DIR = 8'h34;
   localparam logic [7:0] OFF_RESULT = 8'h38;
   localparam logic [7:0] OFF_STATUS = 8'h3C;
   // field positions
   localparam int BIT_RESET_HOLD = 5;
   localparam int BIT_CLOCK_GATE = 5;
   localparam int BIT_RUN = 7;
   localparam int BIT_SCHEME = 6;
   localparam int BIT_COMPARATOR = 0;
   localparam int BIT_TRIG_HI = 7;
   localparam int BIT_RANGE_SENSE = 3;
   localparam int BIT_WIDTH_SEL = 0;
   localparam int BIT_CONV_END = 0;
   // reset values
   localparam logic [7:0] RST_PORT_ANALOG = 8'hFF;
   localparam logic [7:0] RST_PORT_DIR = 8'hFF;
   localparam logic [7:0] RST_UPPER_BOUND = 8'hFF;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK = 8'h01;
   localparam logic [7:0] RST_PRIO = 8'h01;
   // timing: conversion length in conversion clocks, stabilisation wait
   localparam logic [4:0] CONV_CLOCKS_NORMAL1 = 5'd19;
   localparam logic [4:0] CONV_CLOCKS_NORMAL2 = 5'd17;
   localparam logic [4:0] STAB_CLOCKS = 5'd8;

   typedef enum logic [1:0] {AMC_IDLE, AMC_STAB, AMC_CONV} amc_state_t;

   typedef struct packed {
      logic [7:0] reset_ctl;
      logic [7:0] clock_en;
      logic [7:0] mode_first;
      logic [7:0] mode_second;
      logic [7:0] mode_third;
      logic [7:0] upper_bound;
      logic [7:0] lower_bound;
      logic [7:0] channel;
      logic [7:0] irq_mask;
      logic [7:0] irq_req;
      logic [7:0] prio_hi;
      logic [7:0] prio_lo;
      logic [7:0] port_analog;
      logic [7:0] port_dir;
      logic [15:0] result;
      amc_state_t state;
      logic [5:0] div_cnt;
      logic [4:0] step_cnt;
      logic [1:0] scan_pos;
      logic [1:0] trig_meta;
      logic trig_prev;
      logic [31:0] prdata;
   } amc_regs_t;

   typedef struct packed {
      logic [3:0] analog_select;
      logic [3:0] output_enable_n;
      logic comparator_on;
      logic conv_clock_en;
      logic unit_reset;
      logic [1:0] channel;
   } amc_analog_t;
endpackage

// ==== verilog/amc_top.sv ====
// converter mode control: reset, clock gate, run, triggers, interrupt, port 2
// assumes an apb master on pclk and an analog core that returns a 10-bit sample
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module amc_top
   import amc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hw_trigger,
   input wire logic [9:0] sample_data,
   output amc_analog_t analog_ctl,
   output logic conv_end_irq,
   output logic [1:0] conv_end_priority
);
   amc_regs_t r;
   amc_regs_t next_r;

   logic wr;
   logic rd;
   logic unit_reset;
   logic clock_gate;
   logic regs_writable;
   logic [5:0] div_max;
   logic [4:0] conv_len;
   logic div_tick;
   logic [1:0] trig_mode;
   logic hw_edge;
   logic [9:0] sample_w;
   logic [7:0] cmp_val;
   logic in_range;
   logic pass;
   logic conv_done;
   logic hit;
   logic [31:0] rd_val;
   logic [15:0] result_w;

   assign wr = psel & penable & pwrite;
   // read data is latched in the setup phase so it stands at the access edge;
   // a flag raised between setup and access shows on the next read
   assign rd = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign unit_reset = r.reset_ctl[BIT_RESET_HOLD];
   assign clock_gate = r.clock_en[BIT_CLOCK_GATE];
   assign regs_writable = clock_gate & ~unit_reset;
   assign trig_mode = r.mode_second[7:6];

   // divide ratio minus one, indexed by divider code
   always_comb
   begin
      unique case (r.mode_first[5:3])
         3'd0: div_max = 6'd63;
         3'd1: div_max = 6'd31;
         3'd2: div_max = 6'd15;
         3'd3: div_max = 6'd7;
         3'd4: div_max = 6'd5;
         3'd5: div_max = 6'd4;
         3'd6: div_max = 6'd3;
         3'd7: div_max = 6'd1;
      endcase
   end

   // timing variant 01 is the shorter conversion, others fall back to normal 1
   assign conv_len = (r.mode_first[2:1] == 2'b01) ? CONV_CLOCKS_NORMAL2 :
                     CONV_CLOCKS_NORMAL1;
   assign div_tick = clock_gate & (r.div_cnt == div_max);
   assign hw_edge = r.trig_meta[1] & ~r.trig_prev;

   // result width: 8-bit mode keeps the top eight bits
   assign sample_w = r.mode_third[BIT_WIDTH_SEL] ? {sample_data[9:2], 2'b00} :
                     sample_data;
   assign cmp_val = sample_w[9:2];
   assign in_range = (cmp_val >= r.lower_bound) && (cmp_val <= r.upper_bound);
   assign pass = r.mode_third[BIT_RANGE_SENSE] ? ~in_range : in_range;
   assign conv_done = (r.state == AMC_CONV) & div_tick & (r.step_cnt == 5'd0);
   assign result_w = {sample_w, 6'b000000};

   // pslverr on access to an unmapped offset; gated writes complete without error
   always_comb
   begin
      hit = 1'b1;
      rd_val = 32'h00000000;
      unique case (paddr)
         OFF_RESET_CTL: rd_val = {24'h000000, r.reset_ctl};
         OFF_CLOCK_EN: rd_val = {24'h000000, r.clock_en};
         OFF_MODE_FIRST: rd_val = {24'h000000, r.mode_first};
         OFF_MODE_SECOND: rd_val = {24'h000000, r.mode_second};
         OFF_MODE_THIRD: rd_val = {24'h000000, r.mode_third};
         OFF_UPPER_BOUND: rd_val = {24'h000000, r.upper_bound};
         OFF_LOWER_BOUND: rd_val = {24'h000000, r.lower_bound};
         OFF_CHANNEL: rd_val = {24'h000000, r.channel};
         OFF_IRQ_MASK: rd_val = {24'h000000, r.irq_mask};
         OFF_IRQ_REQ: rd_val = {24'h000000, r.irq_req};
         OFF_PRIO_HI: rd_val = {24'h000000, r.prio_hi};
         OFF_PRIO_LO: rd_val = {24'h000000, r.prio_lo};
         OFF_PORT_ANALOG: rd_val = {24'h000000, r.port_analog};
         OFF_PORT_DIR: rd_val = {24'h000000, r.port_dir};
         OFF_RESULT: rd_val = {16'h0000, r.result};
         OFF_STATUS: rd_val = {29'h00000000, r.scan_pos, r.state != AMC_IDLE};
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~hit;

   always_comb
   begin
      next_r = r;
      next_r.trig_meta = {r.trig_meta[0], hw_trigger};
      next_r.trig_prev = r.trig_meta[1];
      if (rd)
      begin
         next_r.prdata = rd_val;
      end
      // system-level registers stay writable regardless of the clock gate
      if (wr && paddr == OFF_RESET_CTL)
      begin
         next_r.reset_ctl = pwdata[7:0] & 8'h75;
      end
      if (wr && paddr == OFF_CLOCK_EN)
      begin
         next_r.clock_en = pwdata[7:0] & 8'h75;
      end
      if (wr && paddr == OFF_IRQ_MASK)
      begin
         next_r.irq_mask = pwdata[7:0];
      end
      if (wr && paddr == OFF_PRIO_HI)
      begin
         next_r.prio_hi = pwdata[7:0];
      end
      if (wr && paddr == OFF_PRIO_LO)
      begin
         next_r.prio_lo = pwdata[7:0];
      end
      if (wr && paddr == OFF_PORT_ANALOG)
      begin
         next_r.port_analog = {4'hF, pwdata[3:0]};
      end
      if (wr && paddr == OFF_PORT_DIR)
      begin
         next_r.port_dir = {4'hF, pwdata[3:0]};
      end
      // software clears a pending request by writing 0
      if (wr && paddr == OFF_IRQ_REQ)
      begin
         next_r.irq_req = pwdata[7:0] & r.irq_req;
      end
      if (regs_writable && wr)
      begin
         unique case (paddr)
            OFF_MODE_FIRST: next_r.mode_first = pwdata[7:0];
            OFF_MODE_SECOND: next_r.mode_second = pwdata[7:0] & 8'hE3;
            OFF_MODE_THIRD: next_r.mode_third = pwdata[7:0] & 8'hED;
            OFF_UPPER_BOUND: next_r.upper_bound = pwdata[7:0];
            OFF_LOWER_BOUND: next_r.lower_bound = pwdata[7:0];
            OFF_CHANNEL: next_r.channel = pwdata[7:0] & 8'h9F;
            default: next_r.channel = next_r.channel;
         endcase
      end

      // conversion clock divider
      if (!clock_gate || div_tick)
      begin
         next_r.div_cnt = 6'd0;
      end
      else
      begin
         next_r.div_cnt = r.div_cnt + 6'd1;
      end

      // sequencer: stabilisation and conversion steps advance on conversion clock ticks, idle leaves on any pclk
      unique case (r.state)
         AMC_IDLE:
         begin
            if (r.mode_first[BIT_RUN] && r.mode_first[BIT_COMPARATOR] && clock_gate)
            begin
               if (!r.mode_second[BIT_TRIG_HI])
               begin
                  next_r.state = AMC_CONV;
                  next_r.step_cnt = conv_len;
               end
               else if (hw_edge)
               begin
                  next_r.state = (trig_mode == 2'b11) ? AMC_STAB : AMC_CONV;
                  next_r.step_cnt = (trig_mode == 2'b11) ? STAB_CLOCKS : conv_len;
               end
            end
         end
         AMC_STAB:
         begin
            if (div_tick)
            begin
               if (r.step_cnt == 5'd0)
               begin
                  next_r.state = AMC_CONV;
                  next_r.step_cnt = conv_len;
               end
               else
               begin
                  next_r.step_cnt = r.step_cnt - 5'd1;
               end
            end
         end
         AMC_CONV:
         begin
            if (div_tick)
            begin
               next_r.step_cnt = r.step_cnt - 5'd1;
            end
            if (conv_done)
            begin
               next_r.result = result_w;
               if (pass)
               begin
                  next_r.irq_req[BIT_CONV_END] = 1'b1;
               end
               // scan walks positions 0..3 when the channel field is zero
               if (r.mode_first[BIT_SCHEME] && r.channel == 8'h00)
               begin
                  next_r.scan_pos = r.scan_pos + 2'd1;
               end
               // software trigger repeats; hardware trigger waits for next edge, wait mode 11 clears run
               if (!r.mode_second[BIT_TRIG_HI])
               begin
                  next_r.step_cnt = conv_len;
               end
               else
               begin
                  next_r.state = AMC_IDLE;
                  if (trig_mode == 2'b11)
                  begin
                     next_r.mode_first[BIT_RUN] = 1'b0;
                  end
               end
            end
         end
      endcase

      // stopping run or comparator aborts the conversion in flight
      if (!next_r.mode_first[BIT_RUN] || !next_r.mode_first[BIT_COMPARATOR])
      begin
         next_r.state = AMC_IDLE;
         next_r.scan_pos = 2'd0;
      end
      if (unit_reset)
      begin
         next_r.mode_first = RST_ZERO;
         next_r.mode_second = RST_ZERO;
         next_r.mode_third = RST_ZERO;
         next_r.state = AMC_IDLE;
         next_r.step_cnt = 5'd0;
         next_r.scan_pos = 2'd0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '{reset_ctl: RST_ZERO, clock_en: RST_ZERO, mode_first: RST_ZERO,
                mode_second: RST_ZERO, mode_third: RST_ZERO,
                upper_bound: RST_UPPER_BOUND, lower_bound: RST_ZERO,
                channel: RST_ZERO, irq_mask: RST_IRQ_MASK, irq_req: RST_ZERO,
                prio_hi: RST_PRIO, prio_lo: RST_PRIO,
                port_analog: RST_PORT_ANALOG, port_dir: RST_PORT_DIR,
                result: 16'h0000, state: AMC_IDLE, div_cnt: 6'd0,
                step_cnt: 5'd0, scan_pos: 2'd0, trig_meta: 2'b00,
                trig_prev: 1'b0, prdata: 32'h00000000};
      end
      else
      begin
         r <= next_r;
      end
   end

   assign prdata = r.prdata;
   assign conv_end_irq = r.irq_req[BIT_CONV_END] & ~r.irq_mask[BIT_CONV_END];
   assign conv_end_priority = {r.prio_hi[0], r.prio_lo[0]};
   // one driver for the whole struct; select mode converts the channel field,
   // scan mode the walk position
   assign analog_ctl = '{analog_select: r.port_analog[3:0],
                         output_enable_n: r.port_dir[3:0],
                         comparator_on: r.mode_first[BIT_COMPARATOR] & ~unit_reset,
                         conv_clock_en: clock_gate & ~unit_reset,
                         unit_reset: unit_reset,
                         channel: r.mode_first[BIT_SCHEME] ? r.scan_pos :
                                  r.channel[1:0]};
endmodule
